/* File: common/fep_defs.svh */
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// Flash geometry
`define FEP_ADDR_W       17
`define FEP_DATA_W       32
`define FEP_FLASH_BYTES  17'h18000
`define FEP_WORDS        24576
`define FEP_WADDR_W      15
`define FEP_WORD_LSB     2
`define FEP_BLOCK_LSB    10
`define FEP_PAIR_LSB     11
`define FEP_BLOCK_W      7
`define FEP_PAIR_W       6
`define FEP_PAIRS        48
`define FEP_INBLK_W      8
`define FEP_INBLK_LAST   8'hFF

// Data values
`define FEP_ERASED_WORD  32'hFFFFFFFF
`define FEP_ZERO_WORD    32'h00000000

// Read port indices
`define FEP_PORT_FETCH   0
`define FEP_PORT_DATA    1
`define FEP_PORT_DEBUG   2
`define FEP_NPORTS       3

`endif

/* File: common/fep_pkg.sv */
`include "fep_defs.svh"
`default_nettype none

package fep_pkg;

    // Protection setting of one 2 KB pair
    typedef enum logic [1:0] {
        FEP_PROT_NONE,
        FEP_PROT_RO,
        FEP_PROT_XO
    } fep_prot_e;

    // Array-changing commands
    typedef enum logic {
        FEP_OP_PROGRAM,
        FEP_OP_ERASE
    } fep_op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        FEP_ST_IDLE,
        FEP_ST_ERASE,
        FEP_ST_DONE
    } fep_state_e;

    // Read request from one access path
    typedef struct packed {
        logic                    valid;
        logic [`FEP_ADDR_W-1:0]  addr;
    } fep_rd_req_s;

    // Read answer to one access path
    typedef struct packed {
        logic                    valid;
        logic                    err;
        logic [`FEP_DATA_W-1:0]  data;
    } fep_rd_rsp_s;

    // Program or erase command
    typedef struct packed {
        logic                    valid;
        fep_op_e                 op;
        logic [`FEP_ADDR_W-1:0]  addr;
        logic [`FEP_DATA_W-1:0]  wdata;
    } fep_cmd_s;

    // Protection setting write
    typedef struct packed {
        logic                    valid;
        logic [`FEP_PAIR_W-1:0]  pair;
        fep_prot_e               mode;
    } fep_prot_wr_s;

endpackage

`default_nettype wire

/* File: logic/fep_array.sv */
`include "fep_defs.svh"
`default_nettype none

module fep_array #(
    parameter int WORDS  = `FEP_WORDS,
    parameter int AW     = `FEP_WADDR_W,
    parameter int DW     = `FEP_DATA_W,
    parameter int NPORTS = `FEP_NPORTS
) (
    // Clock
    input  wire logic                i_ref_clk,
    // Write port
    input  wire logic                i_we,
    input  wire logic [AW-1:0]       i_waddr,
    input  wire logic [DW-1:0]       i_wdata,
    // Read ports, combinational
    input  wire logic [NPORTS*AW-1:0] i_raddr,
    output logic      [NPORTS*DW-1:0] o_rdata
);

    logic [DW-1:0] mem_ff [WORDS];

    // Word store, no reset: contents survive like a nonvolatile array
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    // Independent read ports
    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_rd
            assign o_rdata[p*DW +: DW] = mem_ff[i_raddr[p*AW +: AW]];
        end
    endgenerate

endmodule

`default_nettype wire

/* File: logic/fep_ctrl.sv */
`include "fep_defs.svh"
`default_nettype none

// Summary of operation
// - Flash array holds ninety-six kilobytes
// - One-kilobyte blocks erase independently
// - Erase leaves every block bit one
// - Protection per two-kilobyte block pair
// - Pair is unprotected, read-only or execute-only
// - Read-only pair refuses erase and program
// - Execute-only pair refuses erase and program
// - Execute-only pair answers instruction fetches
// - Execute-only pair withholds data, debugger reads
// - Reads answer one cycle, no waits
module fep_ctrl #(
    parameter int PAIRS = `FEP_PAIRS
) (
    // Clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_nrst,
    // Instruction fetch path
    input  wire fep_pkg::fep_rd_req_s      i_fetch_req,
    output var        fep_pkg::fep_rd_rsp_s o_fetch_rsp,
    // Data load path
    input  wire fep_pkg::fep_rd_req_s      i_data_req,
    output var        fep_pkg::fep_rd_rsp_s o_data_rsp,
    // Debugger read path
    input  wire fep_pkg::fep_rd_req_s      i_dbg_req,
    output var        fep_pkg::fep_rd_rsp_s o_dbg_rsp,
    // Program and erase commands
    input  wire fep_pkg::fep_cmd_s         i_cmd,
    output logic                           o_busy,
    output logic                           o_cmd_done,
    output logic                           o_cmd_refused,
    // Protection settings
    input  wire fep_pkg::fep_prot_wr_s     i_prot_wr,
    output logic      [2*PAIRS-1:0]        o_prot_state
);

    localparam int NP = `FEP_NPORTS;
    localparam int AW = `FEP_WADDR_W;
    localparam int DW = `FEP_DATA_W;

    // Request and answer vectors, indexed by path
    fep_pkg::fep_rd_req_s req      [NP];
    fep_pkg::fep_rd_rsp_s rsp_ff   [NP];
    fep_pkg::fep_rd_rsp_s nxt_rsp  [NP];

    // Protection table, one entry per pair
    fep_pkg::fep_prot_e   prot_ff  [PAIRS];

    // Sequencer state
    fep_pkg::fep_state_e         state_ff;
    fep_pkg::fep_state_e         nxt_state;
    logic [`FEP_BLOCK_W-1:0]     blk_ff;
    logic [`FEP_INBLK_W-1:0]     cnt_ff;
    logic                        busy_ff;
    logic                        done_ff;
    logic                        refused_ff;

    // Array ports
    logic                        arr_we;
    logic [AW-1:0]               arr_waddr;
    logic [DW-1:0]               arr_wdata;
    logic [NP*AW-1:0]            arr_raddr;
    logic [NP*DW-1:0]            arr_rdata;

    // Command decode
    logic                        cmd_in_range;
    logic [`FEP_PAIR_W-1:0]      cmd_pair;
    logic                        cmd_locked;
    logic                        cmd_take;
    logic                        cmd_refuse;

    assign req[`FEP_PORT_FETCH] = i_fetch_req;
    assign req[`FEP_PORT_DATA]  = i_data_req;
    assign req[`FEP_PORT_DEBUG] = i_dbg_req;

    // Address check against the array size
    function automatic logic in_range(input logic [`FEP_ADDR_W-1:0] a);
        in_range = (a < `FEP_FLASH_BYTES);
    endfunction

    // Pair index from the bits above the 2 KB boundary
    function automatic logic [`FEP_PAIR_W-1:0] pair_of(
        input logic [`FEP_ADDR_W-1:0] a
    );
        pair_of = a[`FEP_ADDR_W-1:`FEP_PAIR_LSB];
    endfunction

    // Word index within the array
    function automatic logic [AW-1:0] word_of(input logic [`FEP_ADDR_W-1:0] a);
        word_of = a[`FEP_ADDR_W-1:`FEP_WORD_LSB];
    endfunction

    // Storage
    fep_array #(
        .WORDS  (`FEP_WORDS),
        .AW     (AW),
        .DW     (DW),
        .NPORTS (NP)
    ) u_array (
        .i_ref_clk (i_ref_clk),
        .i_we      (arr_we),
        .i_waddr   (arr_waddr),
        .i_wdata   (arr_wdata),
        .i_raddr   (arr_raddr),
        .o_rdata   (arr_rdata)
    );

    // Read addresses and answers for each path
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic ok;
            logic xo_block;

            assign arr_raddr[p*AW +: AW] = word_of(req[p].addr);
            // Execute-only content leaves only on the fetch path
            assign xo_block = (prot_ff[pair_of(req[p].addr)] == fep_pkg::FEP_PROT_XO)
                && (p != `FEP_PORT_FETCH);
            assign ok = in_range(req[p].addr) && !xo_block;

            always_comb begin
                nxt_rsp[p].valid = req[p].valid;
                nxt_rsp[p].err   = req[p].valid && !ok;
                nxt_rsp[p].data  = (req[p].valid && ok)
                    ? arr_rdata[p*DW +: DW] : `FEP_ZERO_WORD;
            end

            // Answer registered at the edge after the request
            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    rsp_ff[p] <= '0;
                end else begin
                    rsp_ff[p] <= nxt_rsp[p];
                end
            end
        end
    endgenerate

    // Protection table updates
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < PAIRS; i++) begin
                prot_ff[i] <= fep_pkg::FEP_PROT_NONE;
            end
        end else if (i_prot_wr.valid && (32'(i_prot_wr.pair) < PAIRS)) begin
            prot_ff[i_prot_wr.pair] <= i_prot_wr.mode;
        end
    end

    // Command acceptance and protection check
    assign cmd_in_range = in_range(i_cmd.addr);
    assign cmd_pair     = pair_of(i_cmd.addr);
    assign cmd_locked   = (prot_ff[cmd_pair] == fep_pkg::FEP_PROT_RO)
                       || (prot_ff[cmd_pair] == fep_pkg::FEP_PROT_XO);
    assign cmd_take     = i_cmd.valid && (state_ff == fep_pkg::FEP_ST_IDLE);
    assign cmd_refuse   = cmd_take && (!cmd_in_range || cmd_locked);

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fep_pkg::FEP_ST_IDLE: begin
                if (cmd_take && !cmd_refuse && (i_cmd.op == fep_pkg::FEP_OP_ERASE)) begin
                    nxt_state = fep_pkg::FEP_ST_ERASE;
                end
            end
            fep_pkg::FEP_ST_ERASE: begin
                if (cnt_ff == `FEP_INBLK_LAST) begin
                    nxt_state = fep_pkg::FEP_ST_DONE;
                end
            end
            fep_pkg::FEP_ST_DONE: begin
                nxt_state = fep_pkg::FEP_ST_IDLE;
            end
            default: begin
                nxt_state = fep_pkg::FEP_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= fep_pkg::FEP_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Block latch and word counter for an erase walk
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blk_ff <= '0;
            cnt_ff <= '0;
        end else if (state_ff == fep_pkg::FEP_ST_IDLE) begin
            blk_ff <= i_cmd.addr[`FEP_ADDR_W-1:`FEP_BLOCK_LSB];
            cnt_ff <= '0;
        end else if (state_ff == fep_pkg::FEP_ST_ERASE) begin
            cnt_ff <= cnt_ff + `FEP_INBLK_W'(1);
        end
    end

    // Array write: erase fills ones, program stores one word
    always_comb begin
        arr_we    = 1'b0;
        arr_waddr = word_of(i_cmd.addr);
        arr_wdata = i_cmd.wdata;
        if (state_ff == fep_pkg::FEP_ST_ERASE) begin
            arr_we    = 1'b1;
            arr_waddr = {blk_ff, cnt_ff};
            arr_wdata = `FEP_ERASED_WORD;
        end else if (cmd_take && !cmd_refuse && (i_cmd.op == fep_pkg::FEP_OP_PROGRAM)) begin
            arr_we    = 1'b1;
        end
    end

    // Status pulses and busy flag
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            busy_ff    <= (nxt_state != fep_pkg::FEP_ST_IDLE);
            refused_ff <= cmd_refuse;
            done_ff    <= (state_ff == fep_pkg::FEP_ST_DONE)
                       || (cmd_take && !cmd_refuse
                           && (i_cmd.op == fep_pkg::FEP_OP_PROGRAM));
        end
    end

    // Outputs
    assign o_fetch_rsp   = rsp_ff[`FEP_PORT_FETCH];
    assign o_data_rsp    = rsp_ff[`FEP_PORT_DATA];
    assign o_dbg_rsp     = rsp_ff[`FEP_PORT_DEBUG];
    assign o_busy        = busy_ff;
    assign o_cmd_done    = done_ff;
    assign o_cmd_refused = refused_ff;

    // Protection table made visible, two bits per pair
    generate
        for (p = 0; p < PAIRS; p++) begin : g_prot_out
            assign o_prot_state[2*p +: 2] = prot_ff[p];
        end
    endgenerate

endmodule

`default_nettype wire

/* File: test/fep_bus_model.sv */
`include "fep_defs.svh"
`default_nettype none
module fep_bus_model (
    // Requests from the bench, one enable per path
    input  wire logic [2:0]          i_en,
    input  wire logic [16:0]         i_addr,
    // Fetch, data and debugger read requests
    output var fep_pkg::fep_rd_req_s o_fetch_req,
    output var fep_pkg::fep_rd_req_s o_data_req,
    output var fep_pkg::fep_rd_req_s o_dbg_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle paths show the inverted address so a stale value never matches
    assign o_fetch_req = '{i_en[0], i_en[0] ? i_addr : ~i_addr};
    assign o_data_req = '{i_en[1], i_en[1] ? i_addr : ~i_addr};
    assign o_dbg_req = '{i_en[2], i_en[2] ? i_addr : ~i_addr};
endmodule
`default_nettype wire

/* File: test/fep_ctrl_checker.sv */
`include "fep_defs.svh"
`default_nettype none
module fep_ctrl_checker #(
    parameter int PAIRS = `FEP_PAIRS
) (
    // Clock and reset
    input wire logic                  i_ref_clk,
    input wire logic                  i_nrst,
    // Read paths
    input wire fep_pkg::fep_rd_req_s  i_fetch_req,
    input wire fep_pkg::fep_rd_rsp_s  o_fetch_rsp,
    input wire fep_pkg::fep_rd_req_s  i_data_req,
    input wire fep_pkg::fep_rd_rsp_s  o_data_rsp,
    input wire fep_pkg::fep_rd_req_s  i_dbg_req,
    input wire fep_pkg::fep_rd_rsp_s  o_dbg_rsp,
    // Commands
    input wire fep_pkg::fep_cmd_s     i_cmd,
    input wire logic                  o_busy,
    input wire logic                  o_cmd_done,
    input wire logic                  o_cmd_refused,
    // Protection
    input wire fep_pkg::fep_prot_wr_s i_prot_wr,
    input wire logic [2*PAIRS-1:0]    o_prot_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Pair modes seen by a data read and a command, command taken, command allowed
    logic [1:0] dmd;
    logic [1:0] cmd_md;
    logic       go;
    logic       ok;
    assign dmd = o_prot_state[2*i_data_req.addr[16:11] +: 2];
    assign cmd_md = o_prot_state[2*i_cmd.addr[16:11] +: 2];
    assign go = i_cmd.valid && !o_busy && !o_cmd_done;
    assign ok = i_cmd.addr < 17'h18000 && cmd_md == 2'h0;

    property p_fetch_lat; i_fetch_req.valid |=> o_fetch_rsp.valid; endproperty
    a_fetch_lat: assert property (p_fetch_lat) else $error("fetch answer late");
    property p_dbg_idle; !i_dbg_req.valid |=> !o_dbg_rsp.valid; endproperty
    a_dbg_idle: assert property (p_dbg_idle) else $error("debug answer unasked");
    property p_xo_data;
        i_data_req.valid && i_data_req.addr < 17'h18000 && dmd == 2'h2
            |=> o_data_rsp.err && o_data_rsp.data == '0;
    endproperty
    a_xo_data: assert property (p_xo_data) else $error("data read leaked");
    property p_fetch_ok; i_fetch_req.valid && i_fetch_req.addr < 17'h18000 |=> !o_fetch_rsp.err;
    endproperty
    a_fetch_ok: assert property (p_fetch_ok) else $error("fetch refused");
    property p_range; i_dbg_req.valid && i_dbg_req.addr >= 17'h18000 |=> o_dbg_rsp.err; endproperty
    a_range: assert property (p_range) else $error("out of range read accepted");
    property p_refuse; go && !ok |=> o_cmd_refused && !o_cmd_done; endproperty
    a_refuse: assert property (p_refuse) else $error("command not refused");
    property p_prog;
        go && ok && i_cmd.op == fep_pkg::FEP_OP_PROGRAM |=> o_cmd_done && !o_cmd_refused;
    endproperty
    a_prog: assert property (p_prog) else $error("program not done");
    property p_erase;
        go && ok && i_cmd.op == fep_pkg::FEP_OP_ERASE |=> o_busy [*8] ##250 (o_cmd_done && !o_busy);
    endproperty
    a_erase: assert property (p_erase) else $error("erase timing wrong");
    property p_prot;
        i_prot_wr.valid && i_prot_wr.pair < PAIRS
            |=> o_prot_state[2*$past(i_prot_wr.pair) +: 2] == $past(i_prot_wr.mode);
    endproperty
    a_prot: assert property (p_prot) else $error("protection not set");
    // Main scenarios reached
    c_erase: cover property (go && ok && i_cmd.op == fep_pkg::FEP_OP_ERASE);
    c_xo_read: cover property (i_data_req.valid && dmd == 2'h2);
    c_refuse: cover property (o_cmd_refused);
endmodule

bind fep_ctrl fep_ctrl_checker #(.PAIRS(PAIRS)) fep_ctrl_checker_inst (
    .i_ref_clk, .i_nrst, .i_fetch_req, .o_fetch_rsp, .i_data_req, .o_data_rsp, .i_dbg_req,
    .o_dbg_rsp, .i_cmd, .o_busy, .o_cmd_done, .o_cmd_refused, .i_prot_wr, .o_prot_state
);
`default_nettype wire

/* File: test/tb.sv */
`include "fep_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Clock, reset, design connections and reference model
    logic                  i_ref_clk;
    logic                  i_nrst;
    logic [2:0]            en;
    logic [16:0]           ra;
    logic [16:0]           a;
    logic [16:0]           aq [$];
    fep_pkg::fep_rd_req_s  fq, dq, gq;
    fep_pkg::fep_rd_rsp_s  fr, dr, gr;
    fep_pkg::fep_cmd_s     cq;
    fep_pkg::fep_prot_wr_s pw;
    logic                  busy, done, refd;
    logic [95:0]           ps;
    logic [31:0]           seed, r;
    logic [31:0]           m [0:24575];
    logic [1:0]            pm [0:47];
    logic [6:0]            blks [4] = '{7'h00, 7'h01, 7'h5E, 7'h5F};
    int                    n_fail, checks_done, cyc;

    // Read requesters standing in for the processor and debugger
    fep_bus_model fep_bus_model_inst (
        .i_en(en), .i_addr(ra), .o_fetch_req(fq), .o_data_req(dq), .o_dbg_req(gq)
    );
    // Controller under test
    fep_ctrl fep_ctrl_inst (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_fetch_req(fq), .o_fetch_rsp(fr),
        .i_data_req(dq), .o_data_rsp(dr), .i_dbg_req(gq), .o_dbg_rsp(gr), .i_cmd(cq),
        .o_busy(busy), .o_cmd_done(done), .o_cmd_refused(refd), .i_prot_wr(pw),
        .o_prot_state(ps)
    );

    // Clock at 100 ns period
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic results();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick();
        @(posedge i_ref_clk);
        #5;
    endtask

    // Request on one path held for one cycle, answer checked after the taking edge
    task automatic rd(int p, logic [16:0] ad);
        fep_pkg::fep_rd_rsp_s e;
        en = 3'(1 << p);
        ra = ad;
        tick();
        e = '{1'b1, 1'b0, m[ad[16:2]]};
        if (ad >= 17'h18000 || (pm[ad[16:11]] == 2'h2 && p != 0)) e = '{1'b1, 1'b1, 32'h0};
        chk("read", e, (p == 0) ? fr : (p == 1) ? dr : gr);
    endtask

    // Command taken, then answer waited for and its delay measured
    task automatic cmd_go(logic op, logic [16:0] ad, logic [31:0] d);
        int n;
        logic ok;
        ok = ad < 17'h18000 && pm[ad[16:11]] == 2'h0;
        en = '0;
        cq = '{1'b1, fep_pkg::fep_op_e'(op), ad, d};
        tick();
        cq.valid = 1'b0;
        chk("busy", ok && op, busy);
        n = 1;
        while (done !== 1'b1 && refd !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        chk("refused", !ok, refd);
        chk("cycles", (ok && op) ? 258 : 1, n);
        if (ok && op) for (int i = 0; i < 256; i++) m[{ad[16:10], i[7:0]}] = '1;
        else if (ok) m[ad[16:2]] = d;
        tick();
    endtask

    task automatic ckp();
        for (int i = 0; i < 48; i++) chk("prot", pm[i], ps[2*i +: 2]);
    endtask

    task automatic setp(int p, logic [1:0] md);
        en = '0;
        pw = '{1'b1, 6'(p), fep_pkg::fep_prot_e'(md)};
        tick();
        pw.valid = 1'b0;
        if (p < 48) pm[p] = md;
        tick();
        ckp();
    endtask

    // Hang guard
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    // Main sequence
    initial begin
        seed = 32'h508C;
        en = '0;
        ra = '0;
        cq = '0;
        pw = '0;
        i_nrst = 1'b0;
        for (int i = 0; i < 48; i++) pm[i] = 2'h0;
        repeat (8) @(posedge i_ref_clk);
        #5 i_nrst = 1'b1;
        chk("busy", 0, busy);
        ckp();
        // Random words in the first and last pairs, read back on every path
        foreach (blks[j]) for (int k = 0; k < 4; k++) begin
            r = xs();
            a = {blks[j], r[7:0], r[9:8]};
            aq.push_back(a);
            cmd_go(1'b0, a, xs());
            for (int p = 0; p < 3; p++) rd(p, a);
        end
        // Erase of block one only, addressed by its last word
        cmd_go(1'b1, 17'h007FC, 32'h0);
        rd(1, 17'h00400);
        rd(2, 17'h007FC);
        foreach (aq[i]) rd(0, aq[i]);
        // Last pair under each mode, erase in its first block and program in its second
        for (int md = 2; md >= 0; md--) begin
            setp(47, 2'(md));
            cmd_go(1'b1, 17'h17800, 32'h0);
            cmd_go(1'b0, aq[15], xs());
            foreach (aq[i]) for (int p = 0; p < 3; p++) rd(p, aq[i]);
        end
        // Mid-run reset clears every pair setting but keeps the array
        setp(47, 2'h2);
        i_nrst = 1'b0;
        tick();
        i_nrst = 1'b1;
        for (int i = 0; i < 48; i++) pm[i] = 2'h0;
        chk("busy", 0, busy);
        ckp();
        rd(1, aq[15]);
        setp(48, 2'h2);
        // Beyond the array
        for (int p = 0; p < 3; p++) rd(p, 17'h18000);
        cmd_go(1'b0, 17'h1FFFC, 32'h0);
        results();
    end
endmodule
`default_nettype wire
